// ---- verilog/adcro_defs.svh ----
`ifndef ADCRO_DEFS_SVH
`define ADCRO_DEFS_SVH

`define ADCRO_RESULT_W 12
`define ADCRO_FRAME_BITS 16
`define ADCRO_LEAD_ZEROS 4
`define ADCRO_SEROUT_BIT 5
`define ADCRO_SCLK_BIT 4
`define ADCRO_FRAME_BIT 3
`define ADCRO_TEST_HI_BIT 11
`define ADCRO_TEST_LO_BIT 10
`define ADCRO_FIFO_DEPTH 4
`define ADCRO_CONV_TIME_NS 1470
`define ADCRO_CLK_NS 50
`define ADCRO_CONV_CYCLES \
  ((`ADCRO_CONV_TIME_NS + `ADCRO_CLK_NS - 1) / `ADCRO_CLK_NS)
`define ADCRO_CNT_RST 5'h00
`define ADCRO_SYNC_STAGES 2'h2

`endif

// ---- verilog/adcro_pkg.sv ----
package adcro_pkg;

  typedef struct packed {
    logic [11:0] dataOut;
    logic [11:0] dataOe;
  } adcro_pins_t;

  typedef enum logic [2:0] {
    SER_IDLE = 3'b001,
    SER_LOAD = 3'b010,
    SER_SHIFT = 3'b100
  } adcro_ser_state_t;

endpackage

// ---- verilog/adcro_fifo.sv ----
`timescale 1ns/100ps
module adcro_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 4
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
  logic [AW:0] count_q, count_d;
  logic push, pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  always_comb
  begin
    inReady = count_q != (AW + 1)'(DEPTH);
    outValid = count_q != '0;
    outData = mem[rdPtr_q];
    push = inValid && inReady;
    pop = outValid && outReady;
    wrPtr_d = push ? bump(wrPtr_q) : wrPtr_q;
    rdPtr_d = pop ? bump(rdPtr_q) : rdPtr_q;
    count_d = count_q + (AW + 1)'(push) - (AW + 1)'(pop);
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
      count_q <= count_d;
    end
  end

  always_ff @(posedge clock)
  begin
    if (push)
      mem[wrPtr_q] <= inData;
  end
endmodule

// ---- verilog/adcro_sync.sv ----
`timescale 1ns/100ps
module adcro_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= asyncIn;
      sync_q <= meta_q;
    end
  end

  assign syncOut = sync_q;
endmodule

// ---- verilog/adcro_output_if.sv ----
`timescale 1ns/100ps
`include "adcro_defs.svh"
// Function
// - mode low selects serial output, high selects parallel, reusing the pins.
// - parallel mode drives the result on twelve pins with bit 11 as the msb.
// - in serial mode the bit 5 pin becomes the serial result output.
// - a serial frame is sixteen bits, four zeros then twelve result bits.
// - after frame sync falls each bit is valid on sixteen falling sclk edges.
// - coding is two's complement for bipolar, straight binary for unipolar.
// - after frame sync falls the shifter advances on each rising sclk edge.
// - parallel outputs enable only while chip select and read are both low.
// - a rising convert start holds the input and begins a conversion, unless a conversion is already busy.
module adcro_output_if #(
  parameter bit BIPOLAR = 1'b1,
  parameter int CONV_CYCLES = `ADCRO_CONV_CYCLES,
  parameter int FIFO_DEPTH = `ADCRO_FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic modeSelect,
  input wire logic convert_start,
  input wire logic chipSelect_n,
  input wire logic read_n,
  input wire logic [11:0] sampleCode,
  input wire logic [11:0] pinIn,
  output logic [11:0] pinOut,
  output logic [11:0] pinOe,
  output logic convBusy,
  output logic resultReady
);
  localparam int RW = `ADCRO_RESULT_W;
  localparam int CW = $clog2(CONV_CYCLES + 1);

  logic [3:0] syncIn;
  logic modeS, convS, csS, rdS;
  logic [2:0] pinSync;
  logic sclkS, fsyncS_n, testS;
  logic sclk_q, fsyncPrev_n_q, conv_q;
  logic sclkRise, sclkFall, frameFall, convRise;

  adcro_sync #(.WIDTH(4)) u_ctlSync (
    .clock(clock),
    .rst_n(rst_n),
    .asyncIn({modeSelect, convert_start, chipSelect_n, read_n}),
    .syncOut(syncIn)
  );
  assign {modeS, convS, csS, rdS} = syncIn;

  adcro_sync #(.WIDTH(3)) u_pinSync (
    .clock(clock),
    .rst_n(rst_n),
    .asyncIn({pinIn[`ADCRO_SCLK_BIT], pinIn[`ADCRO_FRAME_BIT],
      pinIn[`ADCRO_TEST_HI_BIT] | pinIn[`ADCRO_TEST_LO_BIT]}),
    .syncOut(pinSync)
  );
  assign {sclkS, fsyncS_n, testS} = pinSync;

  // edge detectors on synchronised copies
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sclk_q <= 1'b0;
      fsyncPrev_n_q <= 1'b0;
      conv_q <= 1'b0;
    end
    else
    begin
      sclk_q <= sclkS;
      fsyncPrev_n_q <= fsyncS_n;
      conv_q <= convS;
    end
  end
  assign sclkRise = sclkS && !sclk_q;
  assign sclkFall = !sclkS && sclk_q;
  assign frameFall = !fsyncS_n && fsyncPrev_n_q;
  assign convRise = convS && !conv_q;

  // pins stay released until the synchronisers carry real levels
  logic [1:0] settle_q, settle_d;
  logic live;

  always_comb
  begin
    settle_d = live ? settle_q : settle_q + 2'h1;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      settle_q <= 2'h0;
    else
      settle_q <= settle_d;
  end
  assign live = settle_q == `ADCRO_SYNC_STAGES;

  // offset binary sample to output coding
  function automatic logic [RW-1:0] encode(input logic [RW-1:0] code);
    encode = BIPOLAR ? {~code[RW-1], code[RW-2:0]} : code;
  endfunction

  // conversion timer
  logic [CW-1:0] convCnt_q, convCnt_d;
  logic [RW-1:0] held_q, held_d;
  logic convDone;

  always_comb
  begin
    convCnt_d = convCnt_q;
    held_d = held_q;
    convDone = 1'b0;
    if (convRise && convCnt_q == '0)
    begin
      held_d = sampleCode;
      convCnt_d = CW'(CONV_CYCLES);
    end
    else if (convCnt_q != '0)
    begin
      convCnt_d = convCnt_q - 1'b1;
      convDone = convCnt_q == CW'(1);
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      convCnt_q <= '0;
      held_q <= '0;
    end
    else
    begin
      convCnt_q <= convCnt_d;
      held_q <= held_d;
    end
  end
  assign convBusy = convCnt_q != '0;

  // result queue
  logic fifoInReady, fifoValid, fifoPop;
  logic [RW-1:0] fifoData;

  adcro_fifo #(.WIDTH(RW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .inValid(convDone),
    .inReady(fifoInReady),
    .inData(encode(held_q)),
    .outValid(fifoValid),
    .outReady(fifoPop),
    .outData(fifoData)
  );
  assign resultReady = fifoValid;

  // output latch, refreshed when no read or frame is in progress
  logic [RW-1:0] result_q, result_d;
  logic readAct, readAct_q;
  assign readAct = modeS && !csS && !rdS;

  // serial shifter
  adcro_pkg::adcro_ser_state_t state_q, state_d;
  logic [15:0] shift_q, shift_d;
  logic [4:0] bitCnt_q, bitCnt_d;
  logic serOut_q, serOut_d;

  assign fifoPop = fifoValid && !readAct && state_q == adcro_pkg::SER_IDLE;

  always_comb
  begin
    state_d = state_q;
    shift_d = shift_q;
    bitCnt_d = bitCnt_q;
    serOut_d = serOut_q;
    result_d = fifoPop ? fifoData : result_q;
    case (state_q)
      adcro_pkg::SER_IDLE:
      begin
        serOut_d = 1'b0;
        if (!modeS && frameFall && !testS)
          state_d = adcro_pkg::SER_LOAD;
      end
      adcro_pkg::SER_LOAD:
      begin
        shift_d = {{`ADCRO_LEAD_ZEROS{1'b0}}, result_q};
        bitCnt_d = `ADCRO_CNT_RST;
        serOut_d = 1'b0;
        state_d = adcro_pkg::SER_SHIFT;
      end
      adcro_pkg::SER_SHIFT:
      begin
        if (sclkRise)
        begin
          serOut_d = shift_q[15];
          shift_d = {shift_q[14:0], 1'b0};
        end
        if (sclkFall)
          bitCnt_d = bitCnt_q + 5'h01;
        if (modeS || bitCnt_q == 5'(`ADCRO_FRAME_BITS))
          state_d = adcro_pkg::SER_IDLE;
      end
      default:
        state_d = adcro_pkg::SER_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= adcro_pkg::SER_IDLE;
      shift_q <= '0;
      bitCnt_q <= `ADCRO_CNT_RST;
      serOut_q <= 1'b0;
      result_q <= '0;
      readAct_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      shift_q <= shift_d;
      bitCnt_q <= bitCnt_d;
      serOut_q <= serOut_d;
      result_q <= result_d;
      readAct_q <= readAct;
    end
  end

  // pin drivers
  adcro_pkg::adcro_pins_t pins;
  always_comb
  begin
    pins.dataOut = '0;
    pins.dataOe = '0;
    if (!live)
    begin
      pins.dataOut = '0;
      pins.dataOe = '0;
    end
    else if (modeS)
    begin
      pins.dataOut = result_q;
      pins.dataOe = readAct_q ? 12'hFFF : 12'h000;
    end
    else
    begin
      pins.dataOut[`ADCRO_SEROUT_BIT] = serOut_q;
      pins.dataOe[`ADCRO_SEROUT_BIT] = 1'b1;
    end
  end
  assign pinOut = pins.dataOut;
  assign pinOe = pins.dataOe;

  sequence s_frameStart;
    !modeS && frameFall && !testS && state_q == adcro_pkg::SER_IDLE;
  endsequence

  sequence s_loaded;
    state_q == adcro_pkg::SER_SHIFT && shift_q[15:12] == 4'h0;
  endsequence

  a_serial_frame_start: assert property (@(posedge clock) disable iff (!rst_n)
    s_frameStart |-> ##2 s_loaded)
    else $error("frame did not load leading zeros");
  a_parallel_oe_gate: assert property (@(posedge clock) disable iff (!rst_n)
    pinOe[11:6] != 6'h00 |-> modeS && $past(readAct))
    else $error("parallel drivers on without read and select");
  a_hiz_serial_mode: assert property (@(posedge clock) disable iff (!rst_n)
    live && !modeS && $past(!modeS) |-> pinOe == 12'h020)
    else $error("serial mode drives a pin other than serial out");
  a_serial_pin_data: assert property (@(posedge clock) disable iff (!rst_n)
    !modeS |-> pinOut[`ADCRO_SEROUT_BIT] == serOut_q)
    else $error("serial data not on the bit 5 pin");
  a_msb_on_pin: assert property (@(posedge clock) disable iff (!rst_n)
    modeS |-> pinOut[11] == result_q[11])
    else $error("msb not on the top pin");
  a_shift_advance: assert property (@(posedge clock) disable iff (!rst_n)
    state_q == adcro_pkg::SER_SHIFT && sclkRise |=>
      serOut_q == $past(shift_q[15]))
    else $error("shifter did not advance on rising sclk");
  a_frame_length: assert property (@(posedge clock) disable iff (!rst_n)
    bitCnt_q <= 5'h10)
    else $error("frame ran past sixteen edges");
  a_conv_start: assert property (@(posedge clock) disable iff (!rst_n)
    convRise && !convBusy |=> convCnt_q == CW'(CONV_CYCLES))
    else $error("conversion did not start on convert rise");
  a_mode_select: assert property (@(posedge clock) disable iff (!rst_n)
    modeS |-> pinOe[`ADCRO_SEROUT_BIT] == pinOe[11])
    else $error("parallel mode pins not uniform");

  sequence s_bitLaunch;
    state_q == adcro_pkg::SER_SHIFT && sclkRise;
  endsequence

  a_lead_zeros: assert property (@(posedge clock) disable iff (!rst_n)
    s_bitLaunch ##0 (bitCnt_q < 5'h04) |=> serOut_q == 1'b0)
    else $error("leading bit of frame not zero");
  a_frame_end: assert property (@(posedge clock) disable iff (!rst_n)
    state_q == adcro_pkg::SER_SHIFT && bitCnt_q == 5'h10 |=>
      state_q == adcro_pkg::SER_IDLE)
    else $error("frame did not end after sixteen edges");
  a_bit_hold: assert property (@(posedge clock) disable iff (!rst_n)
    state_q == adcro_pkg::SER_SHIFT && !sclkRise |=> $stable(serOut_q))
    else $error("serial bit changed away from a rising sclk");
  a_no_early_bit: assert property (@(posedge clock) disable iff (!rst_n)
    state_q == adcro_pkg::SER_LOAD |-> serOut_q == 1'b0)
    else $error("serial bit launched before the first rising sclk");
  a_done_queued: assert property (@(posedge clock) disable iff (!rst_n)
    convDone && fifoInReady |=> resultReady)
    else $error("finished conversion not queued");
  a_read_hold: assert property (@(posedge clock) disable iff (!rst_n)
    $past(readAct) |-> $stable(result_q))
    else $error("result changed under an active read");
  a_oe_off_idle: assert property (@(posedge clock) disable iff (!rst_n)
    !readAct_q |-> pinOe[11:6] == 6'h00)
    else $error("parallel drivers on while not read");
endmodule

// ---- dv/adcro_host_model.sv ----
`timescale 1ns/100ps
module adcro_host_model (
  output logic sclk,
  output logic frameSync_n,
  input wire logic serialData
);
  initial
  begin
    sclk = 1'b0;
    frameSync_n = 1'b1;
  end

  // one 16 bit frame, sclk still outside it
  task automatic readFrame(output logic [15:0] w);
    w = 16'h0000;
    frameSync_n = 1'b0;
    #400;
    repeat (16)
    begin
      sclk = 1'b1;
      #200;
      sclk = 1'b0;
      w = {w[14:0], serialData};
      #200;
    end
    frameSync_n = 1'b1;
    #400;
  endtask
endmodule

// ---- dv/adc_result_output_interface_tb.sv ----
`timescale 1ns/100ps
module adc_result_output_interface_tb;
  logic clock;
  logic rst_n;
  logic modeSelect;
  logic convert_start;
  logic chipSelect_n;
  logic read_n;
  logic [11:0] sampleCode;
  logic [11:0] pinIn;
  logic [11:0] pinOut;
  logic [11:0] pinOe;
  logic convBusy;
  logic resultReady;
  logic [11:0] pinOutU;
  logic [11:0] pinOeU;
  logic sclk;
  logic frameSync_n;
  logic serialLine;
  logic [31:0] seed = 32'hA788;
  logic [11:0] code;
  logic [11:0] exp4;
  logic [11:0] raw4;
  logic [15:0] w;
  int error_cnt = 0;
  int cmp_count = 0;

  // released data line shows a changing pattern
  assign serialLine = pinOe[5] ? pinOut[5] : clock;
  assign pinIn = {2'b00, 4'h0, serialLine, sclk, frameSync_n, 3'h0};

  adcro_output_if #(.CONV_CYCLES(3)) u_adcro_output_if (
    .clock(clock),
    .rst_n(rst_n),
    .modeSelect(modeSelect),
    .convert_start(convert_start),
    .chipSelect_n(chipSelect_n),
    .read_n(read_n),
    .sampleCode(sampleCode),
    .pinIn(pinIn),
    .pinOut(pinOut),
    .pinOe(pinOe),
    .convBusy(convBusy),
    .resultReady(resultReady)
  );

  // unipolar variant, straight binary coding
  adcro_output_if #(.BIPOLAR(1'b0), .CONV_CYCLES(3)) u_adcro_output_if_uni (
    .clock(clock),
    .rst_n(rst_n),
    .modeSelect(modeSelect),
    .convert_start(convert_start),
    .chipSelect_n(chipSelect_n),
    .read_n(read_n),
    .sampleCode(sampleCode),
    .pinIn(pinIn),
    .pinOut(pinOutU),
    .pinOe(pinOeU),
    .convBusy(),
    .resultReady()
  );

  adcro_host_model u_adcro_host_model (
    .sclk(sclk),
    .frameSync_n(frameSync_n),
    .serialData(serialLine)
  );

  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  function automatic logic [31:0] xs(logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  // bipolar coding: offset binary with msb inverted
  function automatic logic [11:0] expCode(logic [11:0] c);
    return c ^ 12'h800;
  endfunction

  task automatic check(logic [15:0] got, logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic step(int n);
    repeat (n) @(posedge clock);
    #2;
  endtask

  task automatic convert(int i);
    seed = xs(seed);
    code = (i == 0) ? 12'h000 : (i == 1) ? 12'hFFF : seed[11:0];
    sampleCode = code;
    convert_start = 1'b1;
    step(3);
    check(convBusy, 1'b1);
    convert_start = 1'b0;
    step(10);
    check(convBusy, 1'b0);
  endtask

  task automatic pread(logic [11:0] e, logic [11:0] u);
    chipSelect_n = 1'b0;
    read_n = 1'b0;
    step(6);
    check(pinOe, 12'hFFF);
    check(pinOut, e);
    check(pinOeU, 12'hFFF);
    check(pinOutU, u);
    chipSelect_n = 1'b1;
    read_n = 1'b1;
    step(6);
    check(pinOe, 12'h000);
    check(pinOeU, 12'h000);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    rst_n = 1'b0;
    modeSelect = 1'b1;
    convert_start = 1'b0;
    chipSelect_n = 1'b1;
    read_n = 1'b1;
    sampleCode = 12'h000;
    step(5);
    check(pinOe, 12'h000);
    rst_n = 1'b1;
    step(3);
    check(pinOe, 12'h000);
    for (int i = 0; i < 6; i++)
    begin
      convert(i);
      pread(expCode(code), code);
      chipSelect_n = 1'b0;
      step(6);
      check(pinOe, 12'h000);
      chipSelect_n = 1'b1;
      step(2);
    end
    $display("parallel test done");
    modeSelect = 1'b0;
    step(4);
    for (int i = 0; i < 5; i++)
    begin
      convert(i);
      check(pinOe, 12'h020);
      check(pinOeU, 12'h020);
      u_adcro_host_model.readFrame(w);
      check(w, {4'h0, expCode(code)});
    end
    chipSelect_n = 1'b0;
    read_n = 1'b0;
    step(6);
    check(pinOe, 12'h020);
    chipSelect_n = 1'b1;
    read_n = 1'b1;
    $display("serial test done");
    modeSelect = 1'b1;
    step(4);
    chipSelect_n = 1'b0;
    read_n = 1'b0;
    for (int i = 2; i < 7; i++)
    begin
      convert(i);
      if (i == 5)
      begin
        exp4 = expCode(code);
        raw4 = code;
      end
    end
    chipSelect_n = 1'b1;
    read_n = 1'b1;
    step(20);
    check(resultReady, 1'b0);
    pread(exp4, raw4);
    $display("fifo test done");
    tally_and_finish;
  end

  initial
  begin
    #(5000 * 50);
    error_cnt++;
    tally_and_finish;
  end
endmodule
